// [src/cmau_core.v]
// CPU memory access unit: fetch waits, dual pointers, data addressing
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/10ps
`include "cmau_defs.vh"

module cmau_core (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rstn,
    // Avalon-MM slave
    input  wire [9:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    output reg  [1:0]  avs_response,
    // Program fetch request from CPU
    input  wire        fetch_req,
    input  wire [19:0] fetch_addr,
    output wire        fetch_stall,
    output reg         fetch_done,
    output reg  [7:0]  fetch_data,
    // Program flash
    output wire        flash_rd,
    output wire [19:0] flash_addr,
    input  wire [7:0]  flash_rdata,
    // Instruction flow controls
    input  wire        ptr_step,
    input  wire        ptr_used_done,
    input  wire        ext_move_ptr,
    input  wire        ext_move_reg,
    input  wire [7:0]  reg_index_val,
    // External data address
    output reg  [23:0] xdata_addr,
    output wire [23:0] extended_data_ram_base,
    output wire        second_pointer_active
);

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg [7:0] pointer0_low_r;
reg [7:0] pointer0_high_r;
reg [7:0] pointer1_low_r;
reg [7:0] pointer1_high_r;
reg [7:0] pointer0_top_r;
reg [7:0] pointer1_top_r;
reg [7:0] pointer_select_ctrl_r;
reg [7:0] fetch_wait_states_r;
reg [7:0] addressing_mode_ctrl_r;
reg [7:0] port2_latch_r;
reg [7:0] indirect_page_register_r;
reg [7:0] indirect_upper_address_r;
reg [7:0] extended_data_ram_base_relocation_r;
reg [1:0] guard_state_r;
reg [2:0] guard_cnt_r;
reg       ack_r;

wire [7:0] idx = avs_address[9:2];
wire       req = (avs_read | avs_write) & ~ack_r;
wire       wr  = avs_write & ~ack_r & avs_byteenable[0];
wire       rd  = avs_read & ~ack_r;

// One wait cycle on every access
assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

wire sel_now     = pointer_select_ctrl_r[`CMAU_SEL_BIT];
wire toggle_on   = pointer_select_ctrl_r[`CMAU_TOGGLE_BIT];
wire first_down  = pointer_select_ctrl_r[`CMAU_FIRST_DN_BIT];
wire second_down = pointer_select_ctrl_r[`CMAU_SECOND_DN_BIT];
wire page_source_enable = addressing_mode_ctrl_r[`CMAU_PAGE_SRC_BIT];
wire guard_open  = (guard_cnt_r != 3'h0);

assign second_pointer_active = sel_now;

// ----------------------------------------------------------------
// Mapped index check
// ----------------------------------------------------------------
reg mapped;
always @* begin
    case (idx)
        `CMAU_IDX_P0_LOW, `CMAU_IDX_P0_HIGH, `CMAU_IDX_P1_LOW,
        `CMAU_IDX_P1_HIGH, `CMAU_IDX_SEL_CTRL, `CMAU_IDX_WAIT,
        `CMAU_IDX_P0_TOP, `CMAU_IDX_P1_TOP, `CMAU_IDX_ADDR_MODE,
        `CMAU_IDX_PORT2, `CMAU_IDX_RELOC, `CMAU_IDX_IND_PAGE,
        `CMAU_IDX_IND_UPPER, `CMAU_IDX_GUARD,
        `CMAU_IDX_STATUS: mapped = 1'b1;
        default:          mapped = 1'b0;
    endcase
end

// ----------------------------------------------------------------
// Pointer update values
// ----------------------------------------------------------------
wire [15:0] ptr0     = {pointer0_high_r, pointer0_low_r};
wire [15:0] ptr1     = {pointer1_high_r, pointer1_low_r};
wire [15:0] ptr0_nxt = first_down  ? ptr0 - 16'h0001
                                   : ptr0 + 16'h0001;
wire [15:0] ptr1_nxt = second_down ? ptr1 - 16'h0001
                                   : ptr1 + 16'h0001;
wire step0 = ptr_step & ~sel_now;
wire step1 = ptr_step & sel_now;

// ----------------------------------------------------------------
// Register writes and hardware updates
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        pointer0_low_r           <= `CMAU_ZERO_RESET;
        pointer0_high_r          <= `CMAU_ZERO_RESET;
        pointer1_low_r           <= `CMAU_ZERO_RESET;
        pointer1_high_r          <= `CMAU_ZERO_RESET;
        pointer0_top_r           <= `CMAU_ZERO_RESET;
        pointer1_top_r           <= `CMAU_ZERO_RESET;
        pointer_select_ctrl_r    <= `CMAU_ZERO_RESET;
        fetch_wait_states_r      <= `CMAU_WAIT_RESET;
        addressing_mode_ctrl_r   <= `CMAU_ZERO_RESET;
        port2_latch_r            <= 8'hff;
        indirect_page_register_r <= `CMAU_ZERO_RESET;
        indirect_upper_address_r <= `CMAU_ZERO_RESET;
        extended_data_ram_base_relocation_r   <= `CMAU_ZERO_RESET;
    end else begin
        if (wr) begin
            case (idx)
                `CMAU_IDX_P0_LOW:    pointer0_low_r  <= avs_writedata[7:0];
                `CMAU_IDX_P0_HIGH:   pointer0_high_r <= avs_writedata[7:0];
                `CMAU_IDX_P1_LOW:    pointer1_low_r  <= avs_writedata[7:0];
                `CMAU_IDX_P1_HIGH:   pointer1_high_r <= avs_writedata[7:0];
                `CMAU_IDX_P0_TOP:    pointer0_top_r  <= avs_writedata[7:0];
                `CMAU_IDX_P1_TOP:    pointer1_top_r  <= avs_writedata[7:0];
                `CMAU_IDX_SEL_CTRL:  pointer_select_ctrl_r <=
                    avs_writedata[7:0] & `CMAU_SEL_MASK;
                `CMAU_IDX_WAIT:      fetch_wait_states_r <=
                    avs_writedata[7:0] & `CMAU_WAIT_MASK;
                `CMAU_IDX_ADDR_MODE: addressing_mode_ctrl_r <=
                    avs_writedata[7:0] & `CMAU_MODE_MASK;
                `CMAU_IDX_PORT2:     port2_latch_r <= avs_writedata[7:0];
                `CMAU_IDX_IND_PAGE:
                    indirect_page_register_r <= avs_writedata[7:0];
                `CMAU_IDX_IND_UPPER:
                    indirect_upper_address_r <= avs_writedata[7:0];
                `CMAU_IDX_RELOC:
                    if (guard_open)
                        extended_data_ram_base_relocation_r <= avs_writedata[7:0];
                default: ;
            endcase
        end
        // Hardware step and toggle win over a same-cycle write
        if (step0)
            {pointer0_high_r, pointer0_low_r} <= ptr0_nxt;
        if (step1)
            {pointer1_high_r, pointer1_low_r} <= ptr1_nxt;
        if (ptr_used_done && toggle_on)
            pointer_select_ctrl_r[`CMAU_SEL_BIT] <= ~sel_now;
    end
end

// ----------------------------------------------------------------
// Timed-access guard: key1 then key2 opens a short window
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        guard_state_r <= 2'h0;
        guard_cnt_r   <= 3'h0;
    end else begin
        if (guard_cnt_r != 3'h0)
            guard_cnt_r <= guard_cnt_r - 3'h1;
        if (wr && idx == `CMAU_IDX_GUARD) begin
            if (avs_writedata[7:0] == `CMAU_GUARD_KEY1)
                guard_state_r <= 2'h1;
            else if (guard_state_r == 2'h1 &&
                     avs_writedata[7:0] == `CMAU_GUARD_KEY2) begin
                guard_state_r <= 2'h0;
                guard_cnt_r   <= `CMAU_GUARD_WINDOW;
            end else
                guard_state_r <= 2'h0;
        end else if (wr && idx == `CMAU_IDX_RELOC) begin
            guard_cnt_r <= 3'h0;
        end
    end
end

// ----------------------------------------------------------------
// Bus answer: one wait cycle, data from flops
// ----------------------------------------------------------------
reg [7:0] rd_mux;
always @* begin
    case (idx)
        `CMAU_IDX_P0_LOW:    rd_mux = pointer0_low_r;
        `CMAU_IDX_P0_HIGH:   rd_mux = pointer0_high_r;
        `CMAU_IDX_P1_LOW:    rd_mux = pointer1_low_r;
        `CMAU_IDX_P1_HIGH:   rd_mux = pointer1_high_r;
        `CMAU_IDX_SEL_CTRL:  rd_mux = pointer_select_ctrl_r;
        `CMAU_IDX_WAIT:      rd_mux = fetch_wait_states_r;
        `CMAU_IDX_P0_TOP:    rd_mux = pointer0_top_r;
        `CMAU_IDX_P1_TOP:    rd_mux = pointer1_top_r;
        `CMAU_IDX_ADDR_MODE: rd_mux = addressing_mode_ctrl_r;
        `CMAU_IDX_PORT2:     rd_mux = port2_latch_r;
        `CMAU_IDX_IND_PAGE:  rd_mux = indirect_page_register_r;
        `CMAU_IDX_IND_UPPER: rd_mux = indirect_upper_address_r;
        `CMAU_IDX_RELOC:     rd_mux = extended_data_ram_base_relocation_r;
        `CMAU_IDX_STATUS:    rd_mux = {5'h00, guard_open,
                                       fetch_stall, sel_now};
        default:             rd_mux = 8'h00;
    endcase
end

always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        ack_r        <= 1'b0;
        avs_readdata <= 32'h0000_0000;
        avs_response <= 2'h0;
    end else begin
        ack_r <= req;
        if (req) begin
            avs_readdata <= rd ? {24'h000000, rd_mux} : 32'h0000_0000;
            avs_response <= mapped ? 2'h0 : 2'h3;
        end
    end
end

// ----------------------------------------------------------------
// Program fetch wait states
// ----------------------------------------------------------------
localparam FS_IDLE = 1'b0;
localparam FS_WAIT = 1'b1;
reg       fs_r;
reg [3:0] wait_cnt_r;
reg [3:0] wait_len_r;

wire       fetch_done_nxt = (fs_r == FS_WAIT) && (wait_cnt_r == wait_len_r);

assign fetch_stall = fetch_req & ~fetch_done_nxt;
assign flash_rd    = fetch_req;
assign flash_addr  = fetch_addr;

always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        fs_r       <= FS_IDLE;
        wait_cnt_r <= 4'h0;
        wait_len_r <= 4'h0;
        fetch_done <= 1'b0;
        fetch_data <= 8'h00;
    end else begin
        fetch_done <= 1'b0;
        case (fs_r)
            FS_IDLE: begin
                if (fetch_req && !fetch_done) begin
                    fs_r       <= FS_WAIT;
                    wait_cnt_r <= 4'h0;
                    wait_len_r <= fetch_wait_states_r[3:0];
                end
            end
            FS_WAIT: begin
                if (wait_cnt_r == wait_len_r) begin
                    fs_r       <= FS_IDLE;
                    fetch_done <= 1'b1;
                    fetch_data <= flash_rdata;
                end else
                    wait_cnt_r <= wait_cnt_r + 4'h1;
            end
            default: fs_r <= FS_IDLE;
        endcase
    end
end

// ----------------------------------------------------------------
// External data address
// ----------------------------------------------------------------
always @* begin
    if (ext_move_ptr)
        xdata_addr = sel_now ? {pointer1_top_r, ptr1}
                             : {pointer0_top_r, ptr0};
    else if (ext_move_reg)
        xdata_addr = {indirect_upper_address_r,
                      page_source_enable ? indirect_page_register_r
                                         : port2_latch_r,
                      reg_index_val};
    else
        xdata_addr = 24'h000000;
end

assign extended_data_ram_base = {4'h0, extended_data_ram_base_relocation_r, 12'h000};

endmodule // cmau_core

// [shared/cmau_defs.vh]
// Register map, field positions, reset values and timing constants
`ifndef CMAU_DEFS_VH
`define CMAU_DEFS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define CMAU_IDX_P0_LOW    8'h82
`define CMAU_IDX_P0_HIGH   8'h83
`define CMAU_IDX_P1_LOW    8'h84
`define CMAU_IDX_P1_HIGH   8'h85
`define CMAU_IDX_SEL_CTRL  8'h86
`define CMAU_IDX_WAIT      8'h92
`define CMAU_IDX_P0_TOP    8'h93
`define CMAU_IDX_P1_TOP    8'h95
`define CMAU_IDX_ADDR_MODE 8'h9d
`define CMAU_IDX_PORT2     8'ha0
`define CMAU_IDX_RELOC     8'hc6
`define CMAU_IDX_IND_PAGE  8'hda
`define CMAU_IDX_IND_UPPER 8'hea
`define CMAU_IDX_GUARD     8'hc7
`define CMAU_IDX_STATUS    8'hc8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CMAU_SEL_BIT       0
`define CMAU_TOGGLE_BIT    5
`define CMAU_FIRST_DN_BIT  6
`define CMAU_SECOND_DN_BIT 7
`define CMAU_PAGE_SRC_BIT  3
`define CMAU_SEL_MASK      8'he1
`define CMAU_MODE_MASK     8'h0f
`define CMAU_WAIT_MASK     8'h0f

// ----------------------------------------------------------------
// Reset values and guard keys
// ----------------------------------------------------------------
`define CMAU_WAIT_RESET    8'h07
`define CMAU_ZERO_RESET    8'h00
`define CMAU_GUARD_KEY1    8'haa
`define CMAU_GUARD_KEY2    8'h55
`define CMAU_GUARD_WINDOW  3'h4
`define CMAU_RELOC_SHIFT   12

`endif

// [verif/cmau_assertions.sv]
// Checker of fetch timing, pointer selection and address forming
`timescale 1ns/10ps
module cmau_checker (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rstn,
    // Register bus
    input wire logic [9:0]  avs_address,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    // Fetch and instruction flow
    input wire logic        fetch_req,
    input wire logic        fetch_stall,
    input wire logic        fetch_done,
    input wire logic        ptr_used_done,
    input wire logic        ext_move_ptr,
    input wire logic        ext_move_reg,
    input wire logic [7:0]  reg_index_val,
    // Addresses
    input wire logic [23:0] xdata_addr,
    input wire logic [23:0] extended_data_ram_base,
    input wire logic        second_pointer_active
);
    logic [3:0] wait_r;
    logic       toggle_r;
    logic [4:0] cnt_r;
    wire        wr_sel   = avs_write && avs_address[9:2] == 8'h86;
    wire        wr_reloc = avs_write && avs_address[9:2] == 8'hc6;
    wire        in_fetch = fetch_req && !fetch_done;
    wire [4:0]  span_exp = {1'b0, wait_r} + 5'h02;
    // Shadow of wait field and toggle bit, length of current fetch
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wait_r   <= 4'h7;
            toggle_r <= 1'b0;
            cnt_r    <= 5'h00;
        end else begin
            if (avs_write && avs_address[9:2] == 8'h92)
                wait_r <= avs_writedata[3:0];
            if (wr_sel)
                toggle_r <= avs_writedata[5];
            cnt_r <= in_fetch ? cnt_r + 5'h01 : 5'h00;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    property p_span;
        fetch_done |-> cnt_r == span_exp;
    endproperty
    a_span: assert property (p_span) else $error("fetch length wrong");
    property p_hold;
        in_fetch && cnt_r < span_exp - 5'h01 |-> fetch_stall;
    endproperty
    a_hold: assert property (p_hold) else $error("stall dropped early");
    property p_last;
        in_fetch && !fetch_stall |=> fetch_done;
    endproperty
    a_last: assert property (p_last) else $error("no done after stall");
    property p_pulse;
        fetch_done |=> !fetch_done;
    endproperty
    a_pulse: assert property (p_pulse) else $error("done not a pulse");
    property p_tog;
        ptr_used_done && toggle_r && !wr_sel |=>
            second_pointer_active != $past(second_pointer_active);
    endproperty
    a_tog: assert property (p_tog) else $error("select not toggled");
    property p_keep;
        ptr_used_done && !toggle_r && !wr_sel |=>
            $stable(second_pointer_active);
    endproperty
    a_keep: assert property (p_keep) else $error("select changed");
    property p_low;
        ext_move_reg && !ext_move_ptr |-> xdata_addr[7:0] == reg_index_val;
    endproperty
    a_low: assert property (p_low) else $error("low byte wrong");
    property p_units;
        extended_data_ram_base[11:0] == 12'h000 && extended_data_ram_base[23:20] == 4'h0;
    endproperty
    a_units: assert property (p_units) else $error("base off 4KB grid");
    property p_guard;
        $changed(extended_data_ram_base) |-> $past(wr_reloc);
    endproperty
    a_guard: assert property (p_guard) else $error("base changed");
    c_fetch: cover property (fetch_done);
    c_tog: cover property (ptr_used_done && toggle_r);
    c_keep: cover property (ptr_used_done && !toggle_r);
    c_reg: cover property (ext_move_reg && !ext_move_ptr);
endmodule // cmau_checker
bind cmau_core cmau_checker chk_u (.ref_clk, .rstn, .avs_address, .avs_write,
    .avs_writedata, .fetch_req, .fetch_stall, .fetch_done, .ptr_used_done,
    .ext_move_ptr, .ext_move_reg, .reg_index_val, .xdata_addr, .extended_data_ram_base,
    .second_pointer_active);

// [verif/cmau_flash_model.sv]
// Program flash model with a read latency in clock cycles
`timescale 1ns/10ps
module cmau_flash_model #(
    parameter int ACCESS_CYC = 2
) (
    // Clock
    input  wire logic        ref_clk,
    // Read port
    input  wire logic        flash_rd,
    input  wire logic [19:0] flash_addr,
    output logic      [7:0]  flash_rdata
);
    logic [3:0] lat_r  = 4'h0;
    logic [7:0] data_r = 8'h00;
    assign flash_rdata = data_r;
    // Output flips every cycle until the access time has passed
    always @(posedge ref_clk) begin
        if (flash_rd && lat_r >= ACCESS_CYC)
            data_r <= flash_addr[7:0] ^ flash_addr[15:8];
        else
            data_r <= ~data_r;
        if (!flash_rd)
            lat_r <= 4'h0;
        else if (lat_r < 4'hf)
            lat_r <= lat_r + 4'h1;
    end
endmodule // cmau_flash_model

// [verif/tb_top.sv]
// Self-checking bench for the CPU memory access unit
`timescale 1ns/10ps
module tb_top;
    logic        ref_clk = 1'b0, rstn = 1'b0;
    logic [9:0]  avs_address = 10'h000;
    logic        avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic        avs_waitrequest, fetch_stall, fetch_done, flash_rd;
    logic [1:0]  avs_response, rs;
    logic        fetch_req = 1'b0;
    logic [19:0] fetch_addr = 20'h0, flash_addr;
    logic [7:0]  fetch_data, flash_rdata, rd, fx;
    logic        ptr_step = 1'b0, ptr_used_done = 1'b0;
    logic        ext_move_ptr = 1'b0, ext_move_reg = 1'b0;
    logic [7:0]  reg_index_val = 8'h00;
    logic [23:0] xdata_addr, extended_data_ram_base;
    logic        second_pointer_active;
    integer      failures = 0, checks = 0, n, i;
    logic [15:0] rst_tab [0:11] = '{16'h8200, 16'h8300, 16'h8400, 16'h8500,
        16'h8600, 16'h9207, 16'h9300, 16'h9500, 16'hc600, 16'hea00,
        16'ha0ff, 16'h9d00};
    always #12.5 ref_clk = ~ref_clk;
    cmau_core dut_u (.ref_clk, .rstn, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
        .avs_waitrequest, .avs_response, .fetch_req, .fetch_addr, .fetch_stall,
        .fetch_done, .fetch_data, .flash_rd, .flash_addr, .flash_rdata,
        .ptr_step, .ptr_used_done, .ext_move_ptr, .ext_move_reg,
        .reg_index_val,
        .xdata_addr, .extended_data_ram_base, .second_pointer_active);
    cmau_flash_model #(.ACCESS_CYC(2)) flash_u (.ref_clk, .flash_rd,
        .flash_addr, .flash_rdata);
    task chk(input logic [23:0] got, input logic [23:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        avs_address <= {idx, 2'b00};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h000000, wd};
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        rd = avs_readdata[7:0];
        rs = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task pulse(input logic stp);
        ptr_step <= stp;
        ptr_used_done <= !stp;
        @(posedge ref_clk);
        ptr_step <= 1'b0;
        ptr_used_done <= 1'b0;
        @(posedge ref_clk);
    endtask
    task fetch(input logic [3:0] w);
        bus(1'b1, 8'h92, {4'ha, w});
        bus(1'b0, 8'h92, 8'h00);
        chk({16'h0, rd}, {20'h0, w});
        fetch_addr <= {4'h3, 8'h5a, 4'h0, w};
        fx = 8'h5a ^ {4'h0, w};
        fetch_req <= 1'b1;
        n = 0;
        @(posedge ref_clk);
        while (fetch_done !== 1'b1 && n < 40) begin
            n = n + 1;
            @(posedge ref_clk);
        end
        fetch_req <= 1'b0;
        @(posedge ref_clk);
        chk(n[23:0], {20'h0, w} + 24'h2);
        if (w >= 4'h2) chk({16'h0, fetch_data}, {16'h0, fx});
    endtask
    task summarize;
        if (failures == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        failures = failures + 1;
        summarize;
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        for (i = 0; i < 12; i = i + 1) begin
            bus(1'b0, rst_tab[i][15:8], 8'h00);
            chk({16'h0, rd}, {16'h0, rst_tab[i][7:0]});
        end
        bus(1'b0, 8'h10, 8'h00);
        chk({22'h0, rs}, 24'h3);
        chk({16'h0, rd}, 24'h0);
        fetch(4'h0);
        fetch(4'h2);
        fetch(4'hf);
        fetch(4'h7);
        bus(1'b1, 8'h93, 8'h12);
        bus(1'b1, 8'h83, 8'h34);
        bus(1'b1, 8'h82, 8'hff);
        bus(1'b1, 8'h95, 8'hab);
        bus(1'b1, 8'h85, 8'hcd);
        bus(1'b1, 8'h84, 8'hef);
        ext_move_ptr <= 1'b1;
        pulse(1'b1);
        chk(xdata_addr, 24'h123500);
        bus(1'b1, 8'h86, 8'h40);
        pulse(1'b1);
        chk(xdata_addr, 24'h1234ff);
        bus(1'b1, 8'h86, 8'h41);
        chk(xdata_addr, 24'habcdef);
        pulse(1'b1);
        chk(xdata_addr, 24'habcdf0);
        bus(1'b1, 8'h86, 8'h81);
        pulse(1'b1);
        chk(xdata_addr, 24'habcdef);
        pulse(1'b0);
        chk({23'h0, second_pointer_active}, 24'h1);
        bus(1'b1, 8'h86, 8'h20);
        pulse(1'b0);
        chk({23'h0, second_pointer_active}, 24'h1);
        bus(1'b0, 8'h86, 8'h00);
        chk({16'h0, rd}, 24'h21);
        pulse(1'b0);
        bus(1'b0, 8'h86, 8'h00);
        chk({16'h0, rd}, 24'h20);
        ext_move_ptr <= 1'b0;
        ext_move_reg <= 1'b1;
        reg_index_val <= 8'h77;
        bus(1'b1, 8'hea, 8'h5a);
        bus(1'b1, 8'ha0, 8'h3c);
        bus(1'b1, 8'hda, 8'hc3);
        chk(xdata_addr, 24'h5a3c77);
        bus(1'b1, 8'h9d, 8'h08);
        chk(xdata_addr, 24'h5ac377);
        bus(1'b1, 8'hc6, 8'h01);
        chk(extended_data_ram_base, 24'h000000);
        bus(1'b1, 8'hc7, 8'haa);
        bus(1'b1, 8'hc7, 8'h55);
        bus(1'b1, 8'hc6, 8'h01);
        chk(extended_data_ram_base, 24'h001000);
        summarize;
    end
endmodule // tb_top
